// File: src/wwdt_defines.vh
`ifndef WWDT_DEFINES_VH
`define WWDT_DEFINES_VH
// Register byte offsets.
`define WWDT_OFS_REFRESH 6'h00
`define WWDT_OFS_CTRL 6'h04
`define WWDT_OFS_STATUS 6'h08
`define WWDT_OFS_IRQ_STAT 6'h0C
`define WWDT_OFS_IRQ_CLR 6'h10
`define WWDT_OFS_IRQ_EN 6'h14
`define WWDT_OFS_SEC 6'h18
// Refresh write sequence: first key then second key.
`define WWDT_KEY_FIRST 8'h00
`define WWDT_KEY_SECOND 8'hFF
// Control field positions.
`define WWDT_CTRL_TOPS_LO 0
`define WWDT_CTRL_CKS_LO 4
`define WWDT_CTRL_WEND_LO 8
`define WWDT_CTRL_WSTART_LO 12
`define WWDT_CTRL_ACT_LO 16
`define WWDT_CTRL_SLPSTOP 18
`define WWDT_CTRL_RESET 32'h0000_3350
// Action codes.
`define WWDT_ACT_RESET 2'd0
`define WWDT_ACT_NMI 2'd1
`define WWDT_ACT_IRQ 2'd2
// Status bits.
`define WWDT_ST_UNDF 0
`define WWDT_ST_REFERR 1
// Security register bits.
`define WWDT_SEC_NONSEC 0
`define WWDT_SEC_AUTO 1
// AXI responses.
`define WWDT_RESP_OKAY 2'b00
`define WWDT_RESP_SLVERR 2'b10
`endif

// File: src/wwdt_prescaler.v
`timescale 1ns/1ps
`default_nettype none
module wwdt_prescaler #(
   parameter WIDTH = 13
) (
   input wire clk,
   input wire reset,
   input wire run,
   input wire [2:0] sel,
   output reg tick
);
   reg [WIDTH-1:0] cnt_reg;
   reg [WIDTH-1:0] limit;
   always @* begin
      case (sel)
         3'd0: limit = 13'h0003;
         3'd1: limit = 13'h003F;
         3'd2: limit = 13'h007F;
         3'd3: limit = 13'h01FF;
         3'd4: limit = 13'h07FF;
         default: limit = 13'h1FFF;
      endcase
   end
   always @(posedge clk) begin
      if (reset || !run) begin
         cnt_reg <= {WIDTH{1'b0}};
         tick <= 1'b0;
      end else if (cnt_reg >= limit) begin
         cnt_reg <= {WIDTH{1'b0}};
         tick <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 1'b1;
         tick <= 1'b0;
      end
   end
endmodule // wwdt_prescaler
`default_nettype wire

// File: src/wwdt_top.v
// Contract
// - The count clock is the bus clock divided by 4, 64, 128, 512, 2048 or 8192.
// - A 14-bit counter decrements once per divided tick.
// - In auto-start mode counting starts from idle without a refresh and restarts after underflow or refresh error; reset clears the mode.
// - In register-start mode the block idles until a refresh write starts counting.
// - Reset stops counting and restores the counter and all registers.
// - Counting halts on underflow or refresh error.
// - Window start and end positions split the count into allowed and forbidden refresh periods.
// - Underflow or a refresh outside the window can request a system reset.
// - Instead of reset, underflow or refresh error can raise a non-maskable interrupt or interrupt.
// - Software reads the live counter through the counter status register.
// - Separate event pulses mark underflow and refresh error.
// - Reset request, interrupt request and sleep count-stop control are driven out.
// - A security attribution limits which security state may access the block.
// - Only secure software may choose auto-start or register-start mode.
`timescale 1ns/1ps
`default_nettype none
`include "wwdt_defines.vh"
module wwdt_top #(
   parameter CW = 14
) (
   input wire clk,
   input wire reset,
   input wire [5:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [5:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire sleep_mode,
   output reg reset_req,
   output reg nmi_req,
   output reg irq,
   output reg evt_underflow,
   output reg evt_refresh_error,
   output reg sleep_count_stop
);
   // Running states.
   localparam ST_IDLE = 2'd0;
   localparam ST_RUN = 2'd1;
   localparam ST_HALT = 2'd2;

   reg [1:0] state_reg;
   reg [CW-1:0] count_reg;
   reg [31:0] ctrl_reg;
   reg [1:0] irq_stat_reg;
   reg [1:0] irq_en_reg;
   reg [1:0] sec_reg;
   reg key_armed_reg;
   reg [5:0] aw_addr_reg;
   reg aw_have_reg;
   reg [31:0] w_data_reg;
   reg [3:0] w_strb_reg;
   reg w_have_reg;
   reg aw_sec_reg;
   reg [5:0] ar_addr_reg;
   reg ar_sec_reg;
   reg ar_have_reg;
   reg restart_reg;
   wire tick;

   // Timeout reload value from the two-bit period select.
   function [CW-1:0] timeout_of;
      input [1:0] tops;
      begin
         case (tops)
            2'd0: timeout_of = 14'h03FF;
            2'd1: timeout_of = 14'h0FFF;
            2'd2: timeout_of = 14'h1FFF;
            default: timeout_of = 14'h3FFF;
         endcase
      end
   endfunction

   // Window position as a count threshold: 0 = 0 %, 1 = 25 %, 2 = 50 %, 3 = 75 % of the range.
   function [CW-1:0] pos_of;
      input [1:0] p;
      input [CW-1:0] top;
      begin
         case (p)
            2'd0: pos_of = {CW{1'b0}};
            2'd1: pos_of = {2'b00, top[CW-1:2]};
            2'd2: pos_of = {1'b0, top[CW-1:1]};
            default: pos_of = {1'b0, top[CW-1:1]} + {2'b00, top[CW-1:2]};
         endcase
      end
   endfunction

   wire [CW-1:0] top_val = timeout_of(ctrl_reg[`WWDT_CTRL_TOPS_LO +: 2]);
   // Start at 100 % minus code quarters; end is the lower bound.
   wire [CW-1:0] win_hi = top_val - pos_of(ctrl_reg[`WWDT_CTRL_WSTART_LO +: 2], top_val);
   wire [CW-1:0] win_lo = pos_of(ctrl_reg[`WWDT_CTRL_WEND_LO +: 2], top_val);
   wire in_window = (count_reg <= win_hi) && (count_reg >= win_lo);
   wire auto_mode = sec_reg[`WWDT_SEC_AUTO];

   // Access is blocked when the block is secure-only and the requester is non-secure.
   wire aw_ok = sec_reg[`WWDT_SEC_NONSEC] || !aw_sec_reg;
   wire ar_ok = sec_reg[`WWDT_SEC_NONSEC] || !ar_sec_reg;

   wire do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
   wire wr_refresh = do_write && aw_ok && aw_addr_reg == `WWDT_OFS_REFRESH && w_strb_reg[0];
   wire refresh_ok = wr_refresh && key_armed_reg && w_data_reg[7:0] == `WWDT_KEY_SECOND;
   wire counting = (state_reg == ST_RUN) && !(sleep_count_stop && sleep_mode);
   // The underflow is taken on the tick that would step below zero.
   wire underflow = counting && tick && count_reg == {CW{1'b0}};
   wire ref_err = refresh_ok && state_reg == ST_RUN && !in_window;
   wire ref_good = refresh_ok && !(state_reg == ST_RUN && !in_window);
   wire [1:0] events = {ref_err, underflow};

   wwdt_prescaler #(.WIDTH(13)) u_presc (
      .clk(clk),
      .reset(reset),
      .run(counting),
      .sel(ctrl_reg[`WWDT_CTRL_CKS_LO +: 3]),
      .tick(tick)
   );

   // Counter and state.
   always @(posedge clk) begin
      if (reset) begin
         state_reg <= ST_IDLE;
         count_reg <= {CW{1'b0}};
         restart_reg <= 1'b0;
      end else begin
         restart_reg <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               if (ref_good || auto_mode) begin
                  state_reg <= ST_RUN;
                  count_reg <= top_val;
               end
            end
            ST_RUN: begin
               if (underflow || ref_err) begin
                  state_reg <= ST_HALT;
               end else if (ref_good) begin
                  count_reg <= top_val;
               end else if (counting && tick) begin
                  count_reg <= count_reg - 1'b1;
               end
            end
            ST_HALT: begin
               // Auto-start restarts after one halt cycle; register start waits for a refresh.
               if (auto_mode || ref_good) begin
                  state_reg <= ST_RUN;
                  count_reg <= top_val;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // Event and request outputs.
   always @(posedge clk) begin
      if (reset) begin
         evt_underflow <= 1'b0;
         evt_refresh_error <= 1'b0;
         reset_req <= 1'b0;
         nmi_req <= 1'b0;
         irq <= 1'b0;
         sleep_count_stop <= 1'b0;
      end else begin
         evt_underflow <= underflow;
         evt_refresh_error <= ref_err;
         reset_req <= (|events) && ctrl_reg[`WWDT_CTRL_ACT_LO +: 2] == `WWDT_ACT_RESET;
         nmi_req <= (|events) && ctrl_reg[`WWDT_CTRL_ACT_LO +: 2] == `WWDT_ACT_NMI;
         irq <= |(irq_stat_reg & irq_en_reg);
         sleep_count_stop <= ctrl_reg[`WWDT_CTRL_SLPSTOP];
      end
   end

   // AXI write channel: address and data captured in either order.
   always @(posedge clk) begin
      if (reset) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `WWDT_RESP_OKAY;
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         aw_addr_reg <= 6'h00;
         aw_sec_reg <= 1'b0;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         ctrl_reg <= `WWDT_CTRL_RESET;
         irq_en_reg <= 2'b00;
         sec_reg <= 2'b00;
         key_armed_reg <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_reg <= s_axi_awaddr;
            aw_sec_reg <= s_axi_awprot[1];
            aw_have_reg <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
            w_have_reg <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= aw_ok ? `WWDT_RESP_OKAY : `WWDT_RESP_SLVERR;
            if (wr_refresh) begin
               key_armed_reg <= w_data_reg[7:0] == `WWDT_KEY_FIRST;
            end
            if (aw_ok) begin
               case (aw_addr_reg)
                  `WWDT_OFS_REFRESH: ;
                  `WWDT_OFS_CTRL: ctrl_reg <= w_data_reg;
                  `WWDT_OFS_IRQ_EN: irq_en_reg <= w_data_reg[1:0];
                  `WWDT_OFS_IRQ_CLR: ;
                  // Only a secure writer may touch the attribution and start mode.
                  `WWDT_OFS_SEC: if (!aw_sec_reg) sec_reg <= w_data_reg[1:0];
                  default: s_axi_bresp <= `WWDT_RESP_SLVERR;
               endcase
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Sticky interrupt status: a new event wins over a clear in the same cycle.
   always @(posedge clk) begin
      if (reset) begin
         irq_stat_reg <= 2'b00;
      end else if (do_write && aw_ok && aw_addr_reg == `WWDT_OFS_IRQ_CLR) begin
         irq_stat_reg <= (irq_stat_reg & ~w_data_reg[1:0]) | events;
      end else begin
         irq_stat_reg <= irq_stat_reg | events;
      end
   end

   // AXI read channel.
   always @(posedge clk) begin
      if (reset) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `WWDT_RESP_OKAY;
         ar_have_reg <= 1'b0;
         ar_addr_reg <= 6'h00;
         ar_sec_reg <= 1'b0;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            ar_addr_reg <= s_axi_araddr;
            ar_sec_reg <= s_axi_arprot[1];
            ar_have_reg <= 1'b1;
            s_axi_arready <= 1'b0;
         end
         if (ar_have_reg && !s_axi_rvalid) begin
            ar_have_reg <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `WWDT_RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            if (!ar_ok) begin
               s_axi_rresp <= `WWDT_RESP_SLVERR;
            end else begin
               case (ar_addr_reg)
                  `WWDT_OFS_REFRESH: s_axi_rdata <= 32'h0000_00FF;
                  `WWDT_OFS_CTRL: s_axi_rdata <= ctrl_reg;
                  `WWDT_OFS_STATUS: s_axi_rdata <= {16'h0000, 2'b00, count_reg};
                  `WWDT_OFS_IRQ_STAT: s_axi_rdata <= {30'h0000_0000, irq_stat_reg};
                  `WWDT_OFS_IRQ_CLR: ;
                  `WWDT_OFS_IRQ_EN: s_axi_rdata <= {30'h0000_0000, irq_en_reg};
                  `WWDT_OFS_SEC: s_axi_rdata <= {30'h0000_0000, sec_reg};
                  default: s_axi_rresp <= `WWDT_RESP_SLVERR;
               endcase
            end
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end
endmodule // wwdt_top
`default_nettype wire

// File: sim/wwdt_props.sv
`timescale 1ns/1ps
`default_nettype none
module wwdt_props (
   input wire clk,
   input wire reset,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire reset_req,
   input wire nmi_req,
   input wire evt_underflow,
   input wire evt_refresh_error
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   und_pulse_a: assert property (evt_underflow |=> !evt_underflow) else $error("underflow pulse too long");
   err_pulse_a: assert property (evt_refresh_error |=> !evt_refresh_error) else $error("error pulse too long");
   rst_pulse_a: assert property (reset_req |=> !reset_req) else $error("reset request too long");
   act_excl_a: assert property (!(reset_req && nmi_req)) else $error("reset and nmi together");
   act_cause_a: assert property ((reset_req || nmi_req) |-> (evt_underflow || evt_refresh_error))
      else $error("request without event");
   rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid) else $error("read late");
   rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
   wr_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid) else $error("write late");
   und_c: cover property (evt_underflow);
   err_c: cover property (evt_refresh_error);
   nmi_c: cover property (nmi_req);
endmodule // wwdt_props
bind wwdt_top wwdt_props u_props (.clk, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .reset_req, .nmi_req, .evt_underflow,
   .evt_refresh_error);
`default_nettype wire

// File: sim/wwdt_sys_model.sv
`timescale 1ns/1ps
`default_nettype none
module wwdt_sys_model (
   input wire clk,
   input wire reset_req,
   input wire nmi_req,
   input wire evt_underflow,
   input wire evt_refresh_error,
   output var int n_rst,
   output var int n_nmi,
   output var int n_und,
   output var int n_err
);
   // Counts every pulse so the bench can tell a lost or doubled pulse apart.
   int c_rst = 0;
   int c_nmi = 0;
   int c_und = 0;
   int c_err = 0;
   always @(posedge clk) begin
      if (reset_req === 1'b1) c_rst <= c_rst + 1;
      if (nmi_req === 1'b1) c_nmi <= c_nmi + 1;
      if (evt_underflow === 1'b1) c_und <= c_und + 1;
      if (evt_refresh_error === 1'b1) c_err <= c_err + 1;
   end
   assign n_rst = c_rst;
   assign n_nmi = c_nmi;
   assign n_und = c_und;
   assign n_err = c_err;
endmodule // wwdt_sys_model
`default_nettype wire

// File: sim/wwdt_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module wwdt_top_tb;
   logic clk = 0, reset = 1, awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0, slp = 0;
   logic [5:0] aa = 0, ra = 0;
   logic [2:0] ap = 0, rp = 0;
   logic [31:0] wd = 0, rd_d, a;
   logic [1:0] resp;
   wire awr, wr_r, bv, arr, rv, rq, nq, irq, eu, ee, scs;
   wire [1:0] br, rr;
   wire [31:0] rdat;
   int n_mismatch = 0, n_checks = 0, pr, pn, pu, pe, b, k;
   int xr = 0, xn = 0, xu = 0, xe = 0;
   int dv[3] = '{4, 64, 128};
   initial forever #5 clk = ~clk;
   wwdt_top dut (.clk(clk), .reset(reset), .s_axi_awaddr(aa), .s_axi_awprot(ap), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'h f), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
      .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ra), .s_axi_arprot(rp),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
      .s_axi_rready(rrdy), .sleep_mode(slp), .reset_req(rq), .nmi_req(nq), .irq(irq), .evt_underflow(eu),
      .evt_refresh_error(ee), .sleep_count_stop(scs));
   wwdt_sys_model sys (.clk(clk), .reset_req(rq), .nmi_req(nq), .evt_underflow(eu), .evt_refresh_error(ee),
      .n_rst(pr), .n_nmi(pn), .n_und(pu), .n_err(pe));
   task chk(input string s, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s exp %h got %h", s, e, g);
      end
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task tmo;
      n_mismatch++;
      $display("BAD wait exp done got timeout");
      give_verdict;
   endtask
   task wr(input logic [5:0] ad, input logic [31:0] d, input logic [2:0] p);
      int i;
      // Unused protection bits carry random values, which the block must ignore.
      aa <= ad; wd <= d; ap <= p | (3'($urandom) & 3'b101); awv <= 1; wv <= 1; brdy <= 1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (awr && awv) awv <= 0;
         if (wr_r && wv) wv <= 0;
         if (bv === 1'b1) break;
      end
      if (i == 50) tmo;
      resp = br;
      brdy <= 0;
      // One idle edge keeps a following call from lowering and raising bready in one step.
      @(posedge clk);
   endtask
   task rd(input logic [5:0] ad, input logic [2:0] p);
      int i;
      ra <= ad; rp <= p | (3'($urandom) & 3'b101); arv <= 1; rrdy <= 1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (arr && arv) arv <= 0;
         if (rv === 1'b1) break;
      end
      if (i == 50) tmo;
      resp = rr;
      rd_d = rdat;
      rrdy <= 0;
      @(posedge clk);
   endtask
   task kick;
      wr(6'h00, 32'h0000_0000, 0);
      wr(6'h00, 32'h0000_00ff, 0);
   endtask
   // Counts rather than polls the pulses, which may land while a bus task is busy.
   task wev(input int n);
      int i;
      for (i = 0; i < n; i++) begin
         @(posedge clk);
         if (pu + pe > b) break;
      end
      if (i == n) tmo;
   endtask
   task cnts;
      chk("rst_cnt", xr, pr);
      chk("nmi_cnt", xn, pn);
      chk("und_cnt", xu, pu);
      chk("err_cnt", xe, pe);
   endtask
   initial begin
      void'($urandom(32'h01e2_3f9e));
      repeat (4) @(posedge clk);
      reset <= 0;
      rd(6'h04, 0); chk("ctrl", 32'h0000_3350, rd_d);
      rd(6'h08, 0); chk("count", 0, rd_d);
      rd(6'h1c, 0); chk("unmapped", 2, resp);
      wr(6'h18, 1, 3'b010); chk("ns_wr", 2, resp);
      rd(6'h08, 3'b010); chk("ns_rd", 2, resp);
      $display("reset test done");
      for (k = 0; k < 3; k++) begin
         wr(6'h04, k << 4, 0); kick;
         rd(6'h08, 0); a = rd_d;
         repeat (10 * dv[k]) @(posedge clk);
         rd(6'h08, 0); chk("ticks", 1, (a - rd_d) >= 9 && (a - rd_d) <= 11);
      end
      $display("prescale test done");
      wr(6'h04, 0, 0);
      repeat ($urandom_range(300, 20)) @(posedge clk);
      kick; rd(6'h08, 0); chk("reload", 1, rd_d >= 32'h3f8 && rd_d <= 32'h3ff);
      b = pu + pe; wev(4400); xu++; xr++;
      repeat (3) @(posedge clk);
      rd(6'h08, 0); chk("halt", 0, rd_d);
      rd(6'h0c, 0); chk("stat", 1, rd_d);
      $display("underflow test done");
      for (k = 0; k < 3; k++) begin
         wr(6'h04, 32'h0000_3000 | (k << 16), 0); kick;
         b = pu + pe; kick; wev(30); xe++;
         if (k == 0) xr++;
         if (k == 1) xn++;
      end
      cnts;
      $display("refresh error test done");
      rd(6'h0c, 0); chk("stat", 3, rd_d);
      wr(6'h14, 1, 0); repeat (2) @(posedge clk); chk("irq_on", 1, irq);
      wr(6'h14, 0, 0); repeat (2) @(posedge clk); chk("irq_mask", 0, irq);
      wr(6'h14, 3, 0); wr(6'h10, 3, 0); repeat (2) @(posedge clk); chk("irq_clr", 0, irq);
      rd(6'h0c, 0); chk("stat_clr", 0, rd_d);
      $display("interrupt test done");
      wr(6'h18, 2, 0); chk("sec_wr", 0, resp);
      rd(6'h18, 0); chk("sec", 2, rd_d);
      wr(6'h04, 32'h0006_0000, 0); chk("slp_stop", 1, scs);
      b = pu + pe; kick; wev(4400); xu++;
      repeat (8) @(posedge clk);
      rd(6'h08, 0); chk("restart", 1, rd_d >= 32'h3f0 && rd_d <= 32'h3ff);
      slp <= 1;
      repeat (2) @(posedge clk);
      rd(6'h08, 0); a = rd_d;
      repeat (40) @(posedge clk);
      rd(6'h08, 0); chk("sleep", a, rd_d);
      slp <= 0;
      $display("auto and sleep test done");
      reset <= 1;
      repeat (2) @(posedge clk);
      reset <= 0;
      rd(6'h04, 0); chk("ctrl", 32'h0000_3350, rd_d);
      rd(6'h18, 0); chk("sec", 0, rd_d);
      rd(6'h08, 0); chk("count", 0, rd_d);
      cnts;
      $display("second reset test done");
      give_verdict;
   end
endmodule // wwdt_top_tb
`default_nettype wire
